// ---- sensor_status_and_divider_regs_bench.sv ----
// Self-checking bench for the status and channel-3 divider registers
`timescale 1ns/10ps
module sensor_status_and_divider_regs_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] aw_addr = 8'h00;
  logic aw_valid = 1'b0;
  logic [31:0] w_data = 32'h00000000;
  logic w_valid = 1'b0;
  logic b_ready = 1'b0;
  logic [7:0] ar_addr = 8'h00;
  logic ar_valid = 1'b0;
  logic r_ready = 1'b0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [1:0] b_resp, r_resp, rs;
  logic [31:0] r_data, rd;
  logic fin_tick, ref_tick, irq_n, sens_clk;
  logic [5:0] err_evt;
  logic [1:0] err_chan;
  logic [3:0] conv_done;
  logic [27:0] conv_data;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_fin = 0;
  int n_ref = 0;

  // ========================================================
  // Clock, tick counters and hang guard
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (fin_tick === 1'b1) n_fin++;
    if (ref_tick === 1'b1) n_ref++;
    if (cyc == 8000) begin
      n_mismatch++;
      print_verdict;
    end
  end

  ssd_core_model CORE (.clk_i(clk_i), .err_evt_o(err_evt),
    .err_chan_o(err_chan), .conv_done_o(conv_done),
    .conv_data_o(conv_data), .sensor_clk_o(sens_clk));

  ssd_regs_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid),
    .s_axi_awready_o(aw_ready), .s_axi_wdata_i(w_data),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_valid),
    .s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp),
    .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready),
    .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
    .s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data),
    .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid),
    .s_axi_rready_i(r_ready), .err_evt_i(err_evt),
    .err_chan_i(err_chan), .conv_done_i(conv_done),
    .conv_data_i(conv_data), .sensor_clk_i(sens_clk),
    .fin_tick_o(fin_tick), .ref_tick_o(ref_tick),
    .interrupt_out_n_o(irq_n));

  // ========================================================
  // Compare and report
  task chk(input string what, input logic [31:0] exp,
           input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task print_verdict;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ========================================================
  // Bus master: address and data offered together, held till taken
  task wr(input logic [5:0] idx, input logic [15:0] d,
          input logic [1:0] er);
    logic a_on;
    logic w_on;
    @(posedge clk_i);
    aw_addr <= {idx, 2'b00};
    w_data <= {16'h0000, d};
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    a_on = 1'b1;
    w_on = 1'b1;
    while (a_on || w_on) begin
      @(posedge clk_i);
      if (a_on && aw_ready === 1'b1) begin
        aw_valid <= 1'b0;
        a_on = 1'b0;
      end
      if (w_on && w_ready === 1'b1) begin
        w_valid <= 1'b0;
        w_on = 1'b0;
      end
    end
    while (b_valid !== 1'b1) @(posedge clk_i);
    b_ready <= 1'b0;
    chk("write resp", {30'h0, er}, {30'h0, b_resp});
  endtask

  task rd_reg(input logic [5:0] idx, output logic [31:0] d,
              output logic [1:0] r);
    @(posedge clk_i);
    ar_addr <= {idx, 2'b00};
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    @(posedge clk_i);
    while (ar_ready !== 1'b1) @(posedge clk_i);
    ar_valid <= 1'b0;
    while (r_valid !== 1'b1) @(posedge clk_i);
    d = r_data;
    r = r_resp;
    r_ready <= 1'b0;
  endtask

  // Read a mapped register, expect OKAY and the given word
  task rx(input string what, input logic [5:0] idx,
          input logic [15:0] exp);
    rd_reg(idx, rd, rs);
    chk(what, {16'h0000, exp}, rd);
    chk("read resp", {30'h0, ssd_pkg::RESP_OKAY}, {30'h0, rs});
  endtask

  // ========================================================
  // Scenarios
  task t_reset;
    rx("status rst", ssd_pkg::IDX_STAT, 16'h0000);
    rx("div rst", ssd_pkg::IDX_DIV, ssd_pkg::DIV_RST);
    chk("irq idle", 32'h1, {31'h0, irq_n});
    chk("no ref tick", 32'h0, n_ref);
    wr(ssd_pkg::IDX_STAT, 16'hFFFF, ssd_pkg::RESP_OKAY);
    rx("status ro", ssd_pkg::IDX_STAT, 16'h0000);
    rd_reg(6'h20, rd, rs);
    chk("unmapped resp", {30'h0, ssd_pkg::RESP_DECERR}, {30'h0, rs});
    wr(6'h20, 16'h1234, ssd_pkg::RESP_DECERR);
  endtask

  task t_divider;
    int k;
    wr(ssd_pkg::IDX_DIV, 16'h3005, ssd_pkg::RESP_OKAY);
    rx("div rw", ssd_pkg::IDX_DIV, 16'h3005);
    while (ref_tick !== 1'b1) @(posedge clk_i);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ref_tick !== 1'b1);
    chk("ref period", 32'd5, k);
    n_fin = 0;
    CORE.run_sensor(30);
    repeat (10) @(posedge clk_i);
    chk("fin ticks", 32'd10, n_fin);
  endtask

  task t_ready;
    wr(ssd_pkg::IDX_ROUTE, 16'h0001, ssd_pkg::RESP_OKAY);
    wr(ssd_pkg::IDX_CFG, 16'hC000, ssd_pkg::RESP_OKAY);
    CORE.fire_conv(3, 28'hABCDEF1);
    @(posedge clk_i);
    chk("irq ready", 32'h0, {31'h0, irq_n});
    rx("ready set", ssd_pkg::IDX_STAT, 16'h0041);
    rx("ready clr", ssd_pkg::IDX_STAT, 16'h0001);
    rx("upper ch3", 6'h06, 16'h0ABC);
    rx("lower ch3", 6'h07, 16'hDEF1);
    rx("unread clr", ssd_pkg::IDX_STAT, 16'h0000);
    chk("irq off", 32'h1, {31'h0, irq_n});
    CORE.fire_conv(1, 28'h0000777);
    rx("inactive ch", ssd_pkg::IDX_STAT, 16'h0004);
    rx("lower ch1", 6'h03, 16'h0777);
    wr(ssd_pkg::IDX_ROUTE, 16'h0000, ssd_pkg::RESP_OKAY);
    CORE.fire_conv(3, 28'h0000001);
    rx("unrouted rdy", ssd_pkg::IDX_STAT, 16'h0001);
    rx("lower ch3 b", 6'h07, 16'h0001);
  endtask

  task t_errors;
    logic [15:0] e;
    wr(ssd_pkg::IDX_ROUTE, 16'h00FD, ssd_pkg::RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      e = 16'hC000 | (16'h0100 << i);
      CORE.fire_err(i, 2'h3);
      @(posedge clk_i);
      chk("irq err", 32'h0, {31'h0, irq_n});
      rx("err set", ssd_pkg::IDX_STAT, e);
      rx("err clr", ssd_pkg::IDX_STAT, 16'hC000);
    end
    CORE.fire_err(5, 2'h3);
    rx("upper src", 6'h06, 16'h0000);
    rx("err upper clr", ssd_pkg::IDX_STAT, 16'hC000);
    wr(ssd_pkg::IDX_ROUTE, 16'h0001, ssd_pkg::RESP_OKAY);
    CORE.fire_err(5, 2'h3);
    rx("unrouted err", ssd_pkg::IDX_STAT, 16'hC000);
    wr(ssd_pkg::IDX_ROUTE, 16'h00FD, ssd_pkg::RESP_OKAY);
    wr(ssd_pkg::IDX_CFG, 16'h4000, ssd_pkg::RESP_OKAY);
    CORE.fire_err(0, 2'h2);
    rx("idle ch err", ssd_pkg::IDX_STAT, 16'hC000);
    CORE.fire_err(0, 2'h1);
    rx("ch1 err", ssd_pkg::IDX_STAT, 16'h4100);
  endtask

  task t_seq;
    wr(ssd_pkg::IDX_ROUTE, 16'h0001, ssd_pkg::RESP_OKAY);
    wr(ssd_pkg::IDX_MUX, 16'h8001, ssd_pkg::RESP_OKAY);
    CORE.fire_conv(1, 28'h0000456);
    rx("seq partial", ssd_pkg::IDX_STAT, 16'h4004);
    CORE.fire_conv(0, 28'h0000123);
    rx("seq full", ssd_pkg::IDX_STAT, 16'h404C);
    rx("seq clr", ssd_pkg::IDX_STAT, 16'h400C);
  endtask

  // ========================================================
  // Main sequence: reset held five cycles
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset;
    t_divider;
    t_ready;
    t_errors;
    t_seq;
    print_verdict;
  end
endmodule

// ---- ssd_core_model.sv ----
// Stand-in for the conversion core and the channel-3 sensor oscillator
`timescale 1ns/10ps
module ssd_core_model (
  input wire logic clk_i,
  output logic [5:0] err_evt_o,
  output logic [1:0] err_chan_o,
  output logic [3:0] conv_done_o,
  output logic [27:0] conv_data_o,
  output logic sensor_clk_o
);
  // ========================================================
  // Idle values at time zero
  initial begin
    err_evt_o = 6'h00;
    err_chan_o = 2'h0;
    conv_done_o = 4'h0;
    conv_data_o = 28'h0000000;
    sensor_clk_o = 1'b0;
  end

  // One-cycle error pulse; channel scrambled after it
  task fire_err(input int i, input logic [1:0] ch);
    @(posedge clk_i);
    err_evt_o <= 6'h01 << i;
    err_chan_o <= ch;
    @(posedge clk_i);
    err_evt_o <= 6'h00;
    err_chan_o <= ~ch;
  endtask

  // One-cycle result strobe; data not held, so inverted after
  task fire_conv(input int ch, input logic [27:0] d);
    @(posedge clk_i);
    conv_done_o <= 4'h1 << ch;
    conv_data_o <= d;
    @(posedge clk_i);
    conv_done_o <= 4'h0;
    conv_data_o <= ~d;
  endtask

  // oscillator at 1 MHz, far below the divide-by-two limit
  task run_sensor(input int n);
    repeat (n) begin
      sensor_clk_o <= 1'b1;
      #500;
      sensor_clk_o <= 1'b0;
      #500;
    end
  endtask
endmodule

// ---- ssd_pkg.sv ----
// Constants for the status and channel-3 divider register bank
package ssd_pkg;

  // ==========================================================
  // Register indexes (byte address is four times the index)
  localparam logic [5:0] IDX_RES_BASE = 6'h00;
  localparam logic [5:0] IDX_DIV = 6'h17;
  localparam logic [5:0] IDX_STAT = 6'h18;
  localparam logic [5:0] IDX_ROUTE = 6'h19;
  localparam logic [5:0] IDX_CFG = 6'h1A;
  localparam logic [5:0] IDX_MUX = 6'h1B;

  // ==========================================================
  // Divider register fields
  localparam int FIN_LSB = 12;
  localparam int FIN_MSB = 15;
  localparam int FREF_LSB = 0;
  localparam int FREF_MSB = 9;

  // ==========================================================
  // Status register fields
  localparam int ST_CHAN_LSB = 14;
  localparam int ST_ERR_LSB = 8;
  localparam int ST_RDY = 6;

  // ==========================================================
  // Routing and configuration fields
  localparam int ROUTE_ERR_LSB = 2;
  localparam int ROUTE_RDY = 0;
  localparam int CFG_CHAN_LSB = 14;
  localparam int MUX_SEQ = 15;
  localparam int MUX_LAST_LSB = 0;

  // ==========================================================
  // Values after reset
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [15:0] ROUTE_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h2000;
  localparam logic [15:0] MUX_RST = 16'h0000;
  localparam logic [5:0] ERR_RST = 6'h00;
  localparam logic [3:0] FIN_CNT_RST = 4'h0;
  localparam logic [9:0] REF_CNT_RST = 10'h000;

  // ==========================================================
  // Bus answers and result layout
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int RES_W = 28;
  localparam int RES_SPLIT = 16;

endpackage

// ---- ssd_regs_top.sv ----
// Status, routing and channel-3 divider register bank with AXI4-Lite
`timescale 1ns/10ps

module ssd_regs_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [5:0] err_evt_i,
  input wire logic [1:0] err_chan_i,
  input wire logic [3:0] conv_done_i,
  input wire logic [27:0] conv_data_i,
  input wire logic sensor_clk_i,
  output logic fin_tick_o,
  output logic ref_tick_o,
  output logic interrupt_out_n_o
);

  // ==========================================================
  // Helpers
  function automatic logic is_idx(input logic [7:0] addr,
                                  input logic [5:0] idx);
    is_idx = (addr[7:2] == idx);
  endfunction

  function automatic logic [3:0] act_mask(input logic seq,
                                          input logic [1:0] last,
                                          input logic [1:0] chan);
    logic [3:0] m;
    m = 4'h0;
    if (seq) begin
      // Sequence always covers channel 0 up to the last one, at least two
      m = (last == 2'h3) ? 4'hF : (last == 2'h2) ? 4'h7 : 4'h3;
    end else begin
      m = 4'h1 << chan;
    end
    act_mask = m;
  endfunction

  // ==========================================================
  // State
  logic [15:0] div_r, route_r, cfg_r, mux_r;
  logic [5:0] err_r, err_nxt;
  logic [1:0] echan_r, echan_nxt;
  logic rdy_r, rdy_nxt;
  logic [3:0] fresh_r, fresh_nxt;
  logic [3:0] unread_r;
  logic [ssd_pkg::RES_W-1:0] res_mem_r [4];
  logic aw_held_r, w_held_r, bvalid_r, awready_r, wready_r, arready_r;
  logic rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic sens_s1_r, sens_s2_r, sens_s3_r;
  logic [3:0] fin_cnt_r;
  logic [9:0] ref_cnt_r;
  logic fin_tick_r, ref_tick_r, int_n_r;

  // ==========================================================
  // Bus decode
  wire aw_hs = s_axi_awvalid_i & awready_r;
  wire w_hs = s_axi_wvalid_i & wready_r;
  wire ar_hs = s_axi_arvalid_i & arready_r;
  wire commit = aw_held_r & w_held_r & ~bvalid_r;
  wire aw_held_nxt = (aw_held_r | aw_hs) & ~commit;
  wire w_held_nxt = (w_held_r | w_hs) & ~commit;
  wire bvalid_nxt = commit | (bvalid_r & ~s_axi_bready_i);
  wire rvalid_nxt = ar_hs | (rvalid_r & ~s_axi_rready_i);
  wire wr_div = commit & is_idx(awaddr_r, ssd_pkg::IDX_DIV);
  wire wr_route = commit & is_idx(awaddr_r, ssd_pkg::IDX_ROUTE);
  wire wr_cfg = commit & is_idx(awaddr_r, ssd_pkg::IDX_CFG);
  wire wr_mux = commit & is_idx(awaddr_r, ssd_pkg::IDX_MUX);
  wire [7:0] ra = s_axi_araddr_i;
  wire rd_res = (ra[7:5] == 3'h0);
  wire rd_map = rd_res | is_idx(ra, ssd_pkg::IDX_DIV)
                | is_idx(ra, ssd_pkg::IDX_STAT)
                | is_idx(ra, ssd_pkg::IDX_ROUTE)
                | is_idx(ra, ssd_pkg::IDX_CFG)
                | is_idx(ra, ssd_pkg::IDX_MUX);
  wire wr_map = (awaddr_r[7:5] == 3'h0)
                | is_idx(awaddr_r, ssd_pkg::IDX_DIV)
                | is_idx(awaddr_r, ssd_pkg::IDX_STAT)
                | is_idx(awaddr_r, ssd_pkg::IDX_ROUTE)
                | is_idx(awaddr_r, ssd_pkg::IDX_CFG)
                | is_idx(awaddr_r, ssd_pkg::IDX_MUX);
  wire stat_rd = ar_hs & is_idx(ra, ssd_pkg::IDX_STAT);
  wire [1:0] rd_chan = ra[4:3];
  wire upper_rd = ar_hs & rd_res & ~ra[2];
  wire lower_rd = ar_hs & rd_res & ra[2];

  // Byte-lane merge; bits 31:16 never exist so lanes 2 and 3 are dropped
  wire [15:0] wmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [15:0] wval = wdata_r[15:0];

  // ==========================================================
  // Mode and routing decode
  wire seq_mode = mux_r[ssd_pkg::MUX_SEQ];
  wire [1:0] act_chan = cfg_r[ssd_pkg::CFG_CHAN_LSB +: 2];
  wire [3:0] amask = act_mask(seq_mode, mux_r[ssd_pkg::MUX_LAST_LSB +: 2],
                              act_chan);
  wire chan_act = amask[err_chan_i];
  wire [5:0] err_set = err_evt_i & {6{chan_act}}
                       & route_r[ssd_pkg::ROUTE_ERR_LSB +: 6];
  // clear by status or source upper read
  wire err_clr = stat_rd | (upper_rd & (rd_chan == echan_r));
  wire [3:0] done_act = conv_done_i & amask;
  wire route_rdy = route_r[ssd_pkg::ROUTE_RDY];

  // ==========================================================
  // Status next-state; a set in the clearing cycle wins
  always_comb begin
    err_nxt = (err_r & {6{~err_clr}}) | err_set;
    echan_nxt = (|err_set) ? err_chan_i : echan_r;
    fresh_nxt = fresh_r | done_act;
    rdy_nxt = rdy_r & ~stat_rd;
    if (!seq_mode) begin
      fresh_nxt = 4'h0;
      if ((|done_act) && route_rdy) begin
        rdy_nxt = 1'b1;
      end
    end else if ((fresh_nxt & amask) == amask) begin
      // ready once all active channels fresh
      fresh_nxt = 4'h0;
      // ready flag routed only when enabled
      if (route_rdy) begin
        rdy_nxt = 1'b1;
      end
    end
  end

  wire [15:0] stat_val = {echan_r, err_r, 1'b0, rdy_r, 2'h0,
                          unread_r[0], unread_r[1], unread_r[2],
                          unread_r[3]};

  // ==========================================================
  // Read data mux; result words sit low, upper bits zero
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (rd_res && !ra[2]) begin
      rd_val = {20'h00000,
                res_mem_r[rd_chan][ssd_pkg::RES_W-1:ssd_pkg::RES_SPLIT]};
    end else if (rd_res) begin
      rd_val = {16'h0000, res_mem_r[rd_chan][ssd_pkg::RES_SPLIT-1:0]};
    end else if (is_idx(ra, ssd_pkg::IDX_DIV)) begin
      rd_val = {16'h0000, div_r};
    end else if (is_idx(ra, ssd_pkg::IDX_STAT)) begin
      rd_val = {16'h0000, stat_val};
    end else if (is_idx(ra, ssd_pkg::IDX_ROUTE)) begin
      rd_val = {16'h0000, route_r};
    end else if (is_idx(ra, ssd_pkg::IDX_CFG)) begin
      rd_val = {16'h0000, cfg_r};
    end else if (is_idx(ra, ssd_pkg::IDX_MUX)) begin
      rd_val = {16'h0000, mux_r};
    end
  end

  // ==========================================================
  // Write channel handshakes; one write in flight at a time
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bresp_r <= ssd_pkg::RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      bvalid_r <= bvalid_nxt;
      awready_r <= ~aw_held_nxt & ~bvalid_nxt & ~aw_hs;
      wready_r <= ~w_held_nxt & ~bvalid_nxt & ~w_hs;
      if (aw_hs) begin
        awaddr_r <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      if (commit) begin
        bresp_r <= wr_map ? ssd_pkg::RESP_OKAY : ssd_pkg::RESP_DECERR;
      end
    end
  end

  // ==========================================================
  // Read channel; data captured before the read's own side effects
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= ssd_pkg::RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= rd_val;
        rresp_r <= rd_map ? ssd_pkg::RESP_OKAY : ssd_pkg::RESP_DECERR;
      end
    end
  end

  // ==========================================================
  // Writable registers; status and results ignore writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_r <= ssd_pkg::DIV_RST;
      route_r <= ssd_pkg::ROUTE_RST;
      cfg_r <= ssd_pkg::CFG_RST;
      mux_r <= ssd_pkg::MUX_RST;
    end else begin
      if (wr_div) div_r <= (div_r & ~wmask) | (wval & wmask);
      if (wr_route) route_r <= (route_r & ~wmask) | (wval & wmask);
      if (wr_cfg) cfg_r <= (cfg_r & ~wmask) | (wval & wmask);
      if (wr_mux) mux_r <= (mux_r & ~wmask) | (wval & wmask);
    end
  end

  // ==========================================================
  // Status flags and interrupt level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      err_r <= ssd_pkg::ERR_RST;
      echan_r <= 2'h0;
      rdy_r <= 1'b0;
      fresh_r <= 4'h0;
      int_n_r <= 1'b1;
    end else begin
      err_r <= err_nxt;
      echan_r <= echan_nxt;
      rdy_r <= rdy_nxt;
      fresh_r <= fresh_nxt;
      int_n_r <= ~((|err_nxt) | rdy_nxt);
    end
  end

  // ==========================================================
  // Per-channel result store and unread flags
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      wire lower_hit = lower_rd & (rd_chan == 2'(g));
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          unread_r[g] <= 1'b0;
          res_mem_r[g] <= '0;
        end else begin
          // set on store wins over read
          unread_r[g] <= conv_done_i[g] | (unread_r[g] & ~lower_hit);
          if (conv_done_i[g]) res_mem_r[g] <= conv_data_i;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Sensor edge sync; 10 MHz sampling bounds the usable sensor rate
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sens_s1_r <= 1'b0;
      sens_s2_r <= 1'b0;
      sens_s3_r <= 1'b0;
    end else begin
      sens_s1_r <= sensor_clk_i;
      sens_s2_r <= sens_s1_r;
      sens_s3_r <= sens_s2_r;
    end
  end

  wire sens_rise = sens_s2_r & ~sens_s3_r;
  wire [3:0] fin_div = div_r[ssd_pkg::FIN_MSB:ssd_pkg::FIN_LSB];
  wire [9:0] ref_div = div_r[ssd_pkg::FREF_MSB:ssd_pkg::FREF_LSB];
  wire [3:0] fin_inc = fin_cnt_r + 4'h1;
  wire [9:0] ref_inc = ref_cnt_r + 10'h001;
  wire fin_wrap = sens_rise & (fin_div != 4'h0) & (fin_inc >= fin_div);
  wire ref_wrap = (ref_div != 10'h000) & (ref_inc >= ref_div);

  // ==========================================================
  // Dividers; zero divisor is reserved and stops the tick
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fin_cnt_r <= ssd_pkg::FIN_CNT_RST;
      ref_cnt_r <= ssd_pkg::REF_CNT_RST;
      fin_tick_r <= 1'b0;
      ref_tick_r <= 1'b0;
    end else begin
      if (sens_rise) fin_cnt_r <= fin_wrap ? 4'h0 : fin_inc;
      fin_tick_r <= fin_wrap;
      ref_cnt_r <= ref_wrap ? 10'h000 : ref_inc;
      ref_tick_r <= ref_wrap;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign fin_tick_o = fin_tick_r;
  assign ref_tick_o = ref_tick_r;
  assign interrupt_out_n_o = int_n_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ur_event;
    err_evt_i[5] && chan_act && route_r[7];
  endsequence

  a_fin_zero_stop: assert property (fin_div == 4'h0 |=> !fin_tick_o)
    else $error("input tick with zero divisor");
  a_ref_zero_stop: assert property (ref_div == 10'h000 |=> !ref_tick_o)
    else $error("reference tick with zero divisor");
  a_ref_period: assert property (ref_div == 10'h005 && ref_tick_o
      && $stable(div_r) |=> (!ref_tick_o) [*4] ##1 ref_tick_o)
    else $error("reference divide by five wrong");
  a_chan_latest: assert property ((|err_set) |=>
      stat_val[15:14] == $past(err_chan_i))
    else $error("error channel not updated");
  a_err_hold: assert property ((|err_r) && !err_clr |=>
      (err_r & $past(err_r)) == $past(err_r))
    else $error("latched error lost");
  a_ur_latch: assert property (s_ur_event |=> stat_val[13])
    else $error("under-range not latched");
  a_zc_latch: assert property (err_evt_i[0] && chan_act
      && route_r[2] |=> stat_val[8])
    else $error("zero-count not latched");
  a_err_route: assert property (err_r == 6'h00 &&
      route_r[7:2] == 6'h00 |=> err_r == 6'h00)
    else $error("unrouted error reached status");
  a_rdy_single: assert property (!seq_mode && route_rdy
      && (|done_act) |=> rdy_r)
    else $error("ready flag missed in single mode");
  a_rdy_seq: assert property (seq_mode && !rdy_r
      && ((fresh_r | done_act) & amask) != amask |=> !rdy_r)
    else $error("ready flag before all channels fresh");
  a_unread_set: assert property (conv_done_i[0] |=> stat_val[3])
    else $error("unread flag channel zero not set");
  a_unread_clr: assert property (lower_rd && rd_chan == 2'h1
      && !conv_done_i[1] |=> !unread_r[1])
    else $error("unread flag not cleared by read");
  a_stat_resv: assert property (stat_rd |=> s_axi_rdata_o[7] == 1'b0
      && s_axi_rdata_o[5:4] == 2'h0 && s_axi_rdata_o[31:16] == 16'h0000)
    else $error("reserved status bits nonzero");
  a_int_level: assert property (interrupt_out_n_o ==
      !((|err_r) || rdy_r))
    else $error("interrupt level disagrees with status");

endmodule
